//--- pkg/adcpw_pkg.sv
// adcpw_pkg: register map, field layout, reset values and serial frame layout
// of the power-mode and synthesiser feedback divider register group.
// assumes: every user names items as adcpw_pkg::name, nothing is imported.
package adcpw_pkg;

   // serial frame: read flag, 15-bit address, 8-bit data, msb first
   localparam int unsigned ADDR_W       = 15;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned HDR_BITS     = 16;
   localparam int unsigned FRAME_BITS   = 24;
   localparam logic [4:0]  HDR_LAST     = 5'h0F;
   localparam logic [4:0]  FRAME_LAST   = 5'h17;
   localparam logic [4:0]  DATA_FIRST   = 5'h10;

   // register offsets
   localparam logic [14:0] POWER_MODE_SELECT_ADDR   = 15'h0037;
   localparam logic [14:0] TIMESTAMP_CTRL_ADDR      = 15'h003B;
   localparam logic [14:0] REFERENCE_OUT_CTRL_ADDR  = 15'h003C;
   localparam logic [14:0] SYNTH_FBDIV_12_ADDR      = 15'h003D;
   localparam logic [14:0] SYNTH_FBDIV_3_ADDR       = 15'h003E;

   // reset values
   localparam logic [7:0]  POWER_MODE_SELECT_RST    = 8'h4B;
   localparam logic [7:0]  TIMESTAMP_CTRL_RST       = 8'h00;
   localparam logic [7:0]  REFERENCE_OUT_CTRL_RST   = 8'h01;
   localparam logic [7:0]  SYNTH_FBDIV_12_RST       = 8'h00;
   localparam logic [7:0]  SYNTH_FBDIV_3_RST        = 8'h20;
   localparam logic [7:0]  UNMAPPED_READ            = 8'h00;

   // power mode codes
   localparam logic [7:0]  POWER_CODE_REDUCED       = 8'h46;
   localparam logic [7:0]  POWER_CODE_HIGH_PERF     = 8'h4B;

   // field positions
   localparam int unsigned TIMESTAMP_INPUT_ENABLE_BIT  = 0;
   localparam int unsigned REFERENCE_OUTPUT_ENABLE_BIT = 0;
   localparam int unsigned FBDIV_FIRST_LSB  = 0;
   localparam int unsigned FBDIV_SECOND_LSB = 2;
   localparam int unsigned FBDIV_THIRD_LSB  = 0;
   localparam int unsigned FBDIV_THIRD_W    = 6;

   // first and second divider codes to ratios; ratio zero stops the divider
   localparam logic [5:0]  FIRST_RATIO_CODE0  = 6'h05;
   localparam logic [5:0]  FIRST_RATIO_CODE1  = 6'h04;
   localparam logic [5:0]  FIRST_RATIO_CODE2  = 6'h03;
   localparam logic [5:0]  SECOND_RATIO_CODE0 = 6'h01;
   localparam logic [5:0]  SECOND_RATIO_CODE1 = 6'h02;
   localparam logic [5:0]  SECOND_RATIO_CODE2 = 6'h04;
   localparam logic [5:0]  RATIO_STOPPED      = 6'h00;

   // order fault flag positions
   localparam int unsigned FAULT_POWER_WRITE   = 0;
   localparam int unsigned FAULT_DIVIDER_WRITE = 1;

endpackage : adcpw_pkg

//--- rtl/adcpw_fb_div.sv
// adcpw_fb_div: one stage of the synthesiser feedback chain, divides an enable pulse train.
// assumes: tick_in is counted on every mclk it is high (the first stage ties it high); a ratio of zero stops the stage.
`timescale 1ns/1ps
module adcpw_fb_div (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic       tick_in,
   input  wire logic [5:0] ratio,
   output logic            tick_out
);

   logic [5:0] count_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_q  <= 6'h00;
         tick_out <= 1'b0;
      end else if (clear) begin
         count_q  <= 6'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in && (ratio != 6'h00)) begin
            // compare with >= so a smaller ratio written mid-count cannot overrun
            if (count_q >= ratio - 6'h01) begin
               count_q  <= 6'h00;
               tick_out <= 1'b1;
            end else begin
               count_q <= count_q + 6'h01;
            end
         end
      end
   end

endmodule : adcpw_fb_div

//--- rtl/adcpw_pin_sync.sv
// adcpw_pin_sync: three-stage synchroniser for a bus of pin inputs.
// assumes: inputs are asynchronous to mclk; output changes only when stages two and three agree.
`timescale 1ns/1ps
module adcpw_pin_sync #(
   parameter int unsigned WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q       <= RESET_VAL[g];
               s2_q       <= RESET_VAL[g];
               s3_q       <= RESET_VAL[g];
               pin_out[g] <= RESET_VAL[g];
            end else begin
               s1_q <= pin_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // stage one is never compared, only stages two and three
               if (s2_q == s3_q) begin
                  pin_out[g] <= s3_q;
               end
            end
         end
      end
   endgenerate

endmodule : adcpw_pin_sync

//--- rtl/adcpw_regs.sv
// adcpw_regs: power-mode, timestamp, reference output and feedback divider registers
// reached over the serial control port, plus the feedback divider chain they steer.
// assumes: serial pins are oversampled by mclk (sclk well below mclk/8); calibration,
// link, synthesiser enable and reset levels come from other registers on mclk.
`timescale 1ns/1ps

module adcpw_regs (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_sdi,
   input  wire logic calibration_enable,
   input  wire logic serial_link_enable,
   input  wire logic synthesiser_enable,
   input  wire logic synthesiser_reset,
   output logic      spi_sdo_q,
   output logic      spi_sdo_oe_n_q,
   output logic      power_reduced_mode_q,
   output logic      power_code_reserved_q,
   output logic      timestamp_input_enable_q,
   output logic      reference_clock_output_q,
   output logic      sample_tick_q,
   output logic      feedback_tick_q,
   output logic [1:0] order_fault_q
);

   logic [2:0]  pins_s;
   logic        sclk_s;
   logic        cs_n_s;
   logic        sdi_s;
   logic        sclk_prev_q;
   logic        sclk_rise;
   logic        sclk_fall;
   logic [4:0]  bit_cnt_q;
   logic [15:0] frame_q;
   logic        read_q;
   logic [14:0] addr_q;
   logic [7:0]  out_sr_q;
   logic        wr_stb;
   logic [7:0]  wr_data;
   logic [7:0]  rd_data;

   logic [7:0]  power_mode_select_q;
   logic [7:0]  timestamp_input_control_q;
   logic [7:0]  reference_output_control_q;
   logic [7:0]  synth_feedback_divider_first_second_q;
   logic [7:0]  synth_feedback_divider_third_q;

   logic        chain_clear;
   logic [5:0]  first_ratio;
   logic [5:0]  second_ratio;
   logic [5:0]  third_ratio;
   logic        first_tick;

   // chip select idles high
   adcpw_pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h2)
   ) u_pin_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .pin_in  ({spi_sclk, spi_cs_n, spi_sdi}),
      .pin_out (pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign sdi_s  = pins_s[0];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end

   assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_q;
   assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_q;

   // frame receiver: header on rises 0..15, data on rises 16..23
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 5'h00;
         frame_q   <= 16'h0000;
         read_q    <= 1'b0;
         addr_q    <= 15'h0000;
      end else if (cs_n_s) begin
         bit_cnt_q <= 5'h00;
         read_q    <= 1'b0;
      end else if (sclk_rise) begin
         frame_q <= {frame_q[14:0], sdi_s};
         if (bit_cnt_q == adcpw_pkg::HDR_LAST) begin
            read_q <= frame_q[14];
            addr_q <= {frame_q[13:0], sdi_s};
         end
         // extra clocks past one frame are ignored
         if (bit_cnt_q != adcpw_pkg::FRAME_LAST + 5'h01) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   assign wr_stb  = sclk_rise && (bit_cnt_q == adcpw_pkg::FRAME_LAST) && !read_q;
   assign wr_data = {frame_q[6:0], sdi_s};

   // read return: shift out on the falls after rises 16..23, host samples on rises 17..24
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_sr_q       <= 8'h00;
         spi_sdo_q      <= 1'b0;
         spi_sdo_oe_n_q <= 1'b1;
      end else if (cs_n_s) begin
         spi_sdo_q      <= 1'b0;
         spi_sdo_oe_n_q <= 1'b1;
      end else if (sclk_fall && read_q && (bit_cnt_q >= adcpw_pkg::DATA_FIRST)
                   && (bit_cnt_q <= adcpw_pkg::FRAME_LAST)) begin
         spi_sdo_oe_n_q <= 1'b0;
         // bit 7 comes straight from the mux so it stands before the 17th rise
         if (bit_cnt_q == adcpw_pkg::DATA_FIRST) begin
            spi_sdo_q <= rd_data[7];
            out_sr_q  <= {rd_data[6:0], 1'b0};
         end else begin
            spi_sdo_q <= out_sr_q[7];
            out_sr_q  <= {out_sr_q[6:0], 1'b0};
         end
      end
   end

   // read mux; the address is complete one rise before the data phase
   always_comb begin
      unique case (addr_q)
         adcpw_pkg::POWER_MODE_SELECT_ADDR:  rd_data = power_mode_select_q;
         adcpw_pkg::TIMESTAMP_CTRL_ADDR:     rd_data = timestamp_input_control_q;
         adcpw_pkg::REFERENCE_OUT_CTRL_ADDR: rd_data = reference_output_control_q;
         adcpw_pkg::SYNTH_FBDIV_12_ADDR:     rd_data = synth_feedback_divider_first_second_q;
         adcpw_pkg::SYNTH_FBDIV_3_ADDR:      rd_data = synth_feedback_divider_third_q;
         default:                            rd_data = adcpw_pkg::UNMAPPED_READ;
      endcase
   end

   // register file; reserved bits are stored as written so reads echo them
   // one block per register so a write can only reach its own address
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_select_q <= adcpw_pkg::POWER_MODE_SELECT_RST;
      end else if (wr_stb && (addr_q == adcpw_pkg::POWER_MODE_SELECT_ADDR)) begin
         power_mode_select_q <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timestamp_input_control_q <= adcpw_pkg::TIMESTAMP_CTRL_RST;
      end else if (wr_stb && (addr_q == adcpw_pkg::TIMESTAMP_CTRL_ADDR)) begin
         timestamp_input_control_q <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reference_output_control_q <= adcpw_pkg::REFERENCE_OUT_CTRL_RST;
      end else if (wr_stb && (addr_q == adcpw_pkg::REFERENCE_OUT_CTRL_ADDR)) begin
         reference_output_control_q <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         synth_feedback_divider_first_second_q <= adcpw_pkg::SYNTH_FBDIV_12_RST;
      end else if (wr_stb && (addr_q == adcpw_pkg::SYNTH_FBDIV_12_ADDR)) begin
         synth_feedback_divider_first_second_q <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         synth_feedback_divider_third_q <= adcpw_pkg::SYNTH_FBDIV_3_RST;
      end else if (wr_stb && (addr_q == adcpw_pkg::SYNTH_FBDIV_3_ADDR)) begin
         synth_feedback_divider_third_q <= wr_data;
      end
   end

   // sticky host ordering faults; only device reset clears them
   // held until reset so a single misordered write is never missed
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         order_fault_q <= 2'h0;
      end else if (wr_stb) begin
         if ((addr_q == adcpw_pkg::POWER_MODE_SELECT_ADDR)
             && (calibration_enable || serial_link_enable)) begin
            order_fault_q[adcpw_pkg::FAULT_POWER_WRITE] <= 1'b1;
         end
         if (((addr_q == adcpw_pkg::SYNTH_FBDIV_12_ADDR) || (addr_q == adcpw_pkg::SYNTH_FBDIV_3_ADDR))
             && !synthesiser_reset) begin
            order_fault_q[adcpw_pkg::FAULT_DIVIDER_WRITE] <= 1'b1;
         end
      end
   end

   // decoded controls
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_reduced_mode_q <= 1'b0;
      end else begin
         power_reduced_mode_q <= (power_mode_select_q == adcpw_pkg::POWER_CODE_REDUCED);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         power_code_reserved_q <= 1'b0;
      end else begin
         power_code_reserved_q <= (power_mode_select_q != adcpw_pkg::POWER_CODE_REDUCED)
                                  && (power_mode_select_q != adcpw_pkg::POWER_CODE_HIGH_PERF);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timestamp_input_enable_q <= 1'b0;
      end else begin
         timestamp_input_enable_q <= timestamp_input_control_q[adcpw_pkg::TIMESTAMP_INPUT_ENABLE_BIT];
      end
   end

   // gated by the live enable so the output stops with the synthesiser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reference_clock_output_q <= 1'b0;
      end else begin
         reference_clock_output_q <= reference_output_control_q[adcpw_pkg::REFERENCE_OUTPUT_ENABLE_BIT]
                                     && synthesiser_enable;
      end
   end

   // reserved divider codes stop the chain rather than guess a ratio
   always_comb begin
      unique case (synth_feedback_divider_first_second_q[adcpw_pkg::FBDIV_FIRST_LSB +: 2])
         2'h0:    first_ratio = adcpw_pkg::FIRST_RATIO_CODE0;
         2'h1:    first_ratio = adcpw_pkg::FIRST_RATIO_CODE1;
         2'h2:    first_ratio = adcpw_pkg::FIRST_RATIO_CODE2;
         default: first_ratio = adcpw_pkg::RATIO_STOPPED;
      endcase
      unique case (synth_feedback_divider_first_second_q[adcpw_pkg::FBDIV_SECOND_LSB +: 2])
         2'h0:    second_ratio = adcpw_pkg::SECOND_RATIO_CODE0;
         2'h1:    second_ratio = adcpw_pkg::SECOND_RATIO_CODE1;
         2'h2:    second_ratio = adcpw_pkg::SECOND_RATIO_CODE2;
         default: second_ratio = adcpw_pkg::RATIO_STOPPED;
      endcase
      third_ratio = synth_feedback_divider_third_q[adcpw_pkg::FBDIV_THIRD_LSB +: adcpw_pkg::FBDIV_THIRD_W];
   end

   // each mclk cycle stands for one oscillator period of the synthesiser
   assign chain_clear = synthesiser_reset || !synthesiser_enable;

   // reset ratios give a sample tick every 5 mclk and a feedback tick every 160

   adcpw_fb_div u_div_first (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clear    (chain_clear),
      .tick_in  (1'b1),
      .ratio    (first_ratio),
      .tick_out (first_tick)
   );

   adcpw_fb_div u_div_second (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clear    (chain_clear),
      .tick_in  (first_tick),
      .ratio    (second_ratio),
      .tick_out (sample_tick_q)
   );

   adcpw_fb_div u_div_third (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clear    (chain_clear),
      .tick_in  (sample_tick_q),
      .ratio    (third_ratio),
      .tick_out (feedback_tick_q)
   );

endmodule : adcpw_regs

//--- verif/adcpw_regs_props.sv
// adcpw_regs_chk: port-level properties of the power-mode and divider register group.
// assumes: bound onto adcpw_regs, everything on mclk with async rst_n.
`timescale 1ns/1ps
module adcpw_regs_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       spi_sclk,
   input wire logic       spi_cs_n,
   input wire logic       spi_sdi,
   input wire logic       calibration_enable,
   input wire logic       serial_link_enable,
   input wire logic       synthesiser_enable,
   input wire logic       synthesiser_reset,
   input wire logic       spi_sdo_q,
   input wire logic       spi_sdo_oe_n_q,
   input wire logic       power_reduced_mode_q,
   input wire logic       power_code_reserved_q,
   input wire logic       timestamp_input_enable_q,
   input wire logic       reference_clock_output_q,
   input wire logic       sample_tick_q,
   input wire logic       feedback_tick_q,
   input wire logic [1:0] order_fault_q
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   AST_REF_NEEDS_EN: assert property (reference_clock_output_q |-> $past(synthesiser_enable))
      else $error("reference output on without synthesiser enable");
   AST_REF_OFF: assert property (!synthesiser_enable |=> !reference_clock_output_q)
      else $error("reference output stayed on");
   AST_MODE_EXCL: assert property (!(power_reduced_mode_q && power_code_reserved_q))
      else $error("power code both reduced and reserved");
   AST_SAMPLE_GAP: assert property (sample_tick_q |=> !sample_tick_q [*2])
      else $error("sample ticks closer than three cycles");
   AST_CHAIN_HOLD: assert property ((synthesiser_reset || !synthesiser_enable) [*3] |->
      !sample_tick_q && !feedback_tick_q)
      else $error("divider chain ticks while held");
   AST_FB_AFTER_SAMPLE: assert property (feedback_tick_q |-> $past(sample_tick_q))
      else $error("feedback tick without sample tick");
   AST_OE_RELEASE: assert property (spi_cs_n [*6] |-> spi_sdo_oe_n_q && !spi_sdo_q)
      else $error("serial output driven outside frame");
   AST_FAULT0_STICKY: assert property (order_fault_q[0] |=> order_fault_q[0])
      else $error("power order fault lost");
   AST_FAULT1_STICKY: assert property (order_fault_q[1] |=> order_fault_q[1])
      else $error("divider order fault lost");
   cover property (power_reduced_mode_q);
   cover property (feedback_tick_q);
   cover property (!spi_sdo_oe_n_q);
endmodule : adcpw_regs_chk

bind adcpw_regs adcpw_regs_chk adcpw_regs_chk_inst (.mclk(mclk), .rst_n(rst_n), .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .calibration_enable(calibration_enable),
   .serial_link_enable(serial_link_enable), .synthesiser_enable(synthesiser_enable),
   .synthesiser_reset(synthesiser_reset), .spi_sdo_q(spi_sdo_q), .spi_sdo_oe_n_q(spi_sdo_oe_n_q),
   .power_reduced_mode_q(power_reduced_mode_q), .power_code_reserved_q(power_code_reserved_q),
   .timestamp_input_enable_q(timestamp_input_enable_q), .reference_clock_output_q(reference_clock_output_q),
   .sample_tick_q(sample_tick_q), .feedback_tick_q(feedback_tick_q), .order_fault_q(order_fault_q));

//--- verif/adcpw_regs_tb_top.sv
// adcpw_regs_tb_top: serial-port driven test of the register group and divider chain.
// assumes: 200 MHz mclk, sclk at 10 mclk per half period, inputs driven at falling mclk.
`timescale 1ns/1ps
module adcpw_regs_tb_top;
   logic       mclk = 1'b0;
   logic       rst_n, spi_sclk, spi_cs_n, spi_sdi;
   logic       calibration_enable, serial_link_enable, synthesiser_enable, synthesiser_reset;
   logic       spi_sdo_q, spi_sdo_oe_n_q, power_reduced_mode_q, power_code_reserved_q;
   logic       timestamp_input_enable_q, reference_clock_output_q, sample_tick_q, feedback_tick_q;
   logic [1:0] order_fault_q;
   int         error_cnt = 0;
   int         total_checks = 0;

   always #2.5 mclk = ~mclk;

   adcpw_regs adcpw_regs_inst (.mclk(mclk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .calibration_enable(calibration_enable), .serial_link_enable(serial_link_enable),
      .synthesiser_enable(synthesiser_enable), .synthesiser_reset(synthesiser_reset), .spi_sdo_q(spi_sdo_q),
      .spi_sdo_oe_n_q(spi_sdo_oe_n_q), .power_reduced_mode_q(power_reduced_mode_q),
      .power_code_reserved_q(power_code_reserved_q), .timestamp_input_enable_q(timestamp_input_enable_q),
      .reference_clock_output_q(reference_clock_output_q), .sample_tick_q(sample_tick_q),
      .feedback_tick_q(feedback_tick_q), .order_fault_q(order_fault_q));

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   // sdo sampled at each of the last 8 rises, bits change only after falls
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] rq);
      logic [23:0] f;
      f = {rd, a, wd};
      spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_sdi = f[i];
         cyc(10);
         spi_sclk = 1'b1;
         if (i < 8) begin
            rq[i] = spi_sdo_q;
            check(spi_sdo_oe_n_q, !rd);
         end
         cyc(10);
         spi_sclk = 1'b0;
      end
      cyc(10);
      spi_cs_n = 1'b1;
      cyc(12);
   endtask : xfer

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] unused;
      xfer(1'b0, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] rq;
      xfer(1'b1, a, 8'h00, rq);
      check({8'h00, rq}, {8'h00, exp});
      check({spi_sdo_oe_n_q, spi_sdo_q}, 2'b10);
   endtask : rd_chk

   // setdiv changes the divider fields only with the synthesiser held
   task automatic setdiv(input logic [7:0] d12, input logic [7:0] d3);
      synthesiser_reset = 1'b1;
      cyc(2);
      wr(15'h003D, d12);
      wr(15'h003E, d3);
      synthesiser_reset = 1'b0;
   endtask : setdiv

   // counts mclk between two ticks; bound covers the longest ratio used
   task automatic period(input logic fb, input int exp);
      int n;
      n = 0;
      while ((fb ? feedback_tick_q : sample_tick_q) !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      if (n < 1000) begin
         cyc(1);
         n = 1;
         while ((fb ? feedback_tick_q : sample_tick_q) !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
         end
      end
      if (n >= 1000) begin
         error_cnt++;
         final_report();
      end
      check(n[15:0], exp[15:0]);
   endtask : period

   initial begin
      {spi_sclk, spi_sdi, calibration_enable, serial_link_enable, synthesiser_reset} = '0;
      spi_cs_n = 1'b1;
      synthesiser_enable = 1'b1;
      rst_n = 1'b0;
      cyc(6);
      rst_n = 1'b1;
      cyc(10);
      check(reference_clock_output_q, 1'b1);
      check({power_reduced_mode_q, power_code_reserved_q}, 2'b00);
      rd_chk(15'h0037, 8'h4B);
      rd_chk(15'h003B, 8'h00);
      rd_chk(15'h003C, 8'h01);
      rd_chk(15'h003D, 8'h00);
      rd_chk(15'h003E, 8'h20);
      rd_chk(15'h0040, 8'h00);
      $display("test reset values done");
      // companion power registers sit outside this group
      wr(15'h0037, 8'h46);
      check({power_reduced_mode_q, power_code_reserved_q}, 2'b10);
      wr(15'h0037, 8'h55);
      check({power_reduced_mode_q, power_code_reserved_q}, 2'b01);
      wr(15'h0037, 8'h4B);
      check({power_reduced_mode_q, power_code_reserved_q}, 2'b00);
      calibration_enable = 1'b1;
      cyc(4);
      calibration_enable = 1'b0;
      check(order_fault_q, 2'b00);
      wr(15'h003B, 8'h01);
      check(timestamp_input_enable_q, 1'b1);
      rd_chk(15'h003B, 8'h01);
      wr(15'h003B, 8'h00);
      check(timestamp_input_enable_q, 1'b0);
      $display("test power and timestamp done");
      synthesiser_enable = 1'b0;
      cyc(3);
      check(reference_clock_output_q, 1'b0);
      synthesiser_enable = 1'b1;
      cyc(3);
      check(reference_clock_output_q, 1'b1);
      wr(15'h003C, 8'h00);
      check(reference_clock_output_q, 1'b0);
      wr(15'h003C, 8'h01);
      $display("test reference output done");
      period(1'b0, 5);
      period(1'b1, 160);
      for (int v = 0; v < 3; v++) begin
         setdiv({6'h00, v[1:0]}, 8'h01);
         period(1'b0, 5 - v);
         period(1'b1, 5 - v);
      end
      for (int p = 0; p < 3; p++) begin
         setdiv({4'h0, p[1:0], 2'h2}, 8'h3F);
         period(1'b0, 3 << p);
         period(1'b1, (3 << p) * 63);
      end
      rd_chk(15'h003D, 8'h0A);
      $display("test divider chain done");
      wr(15'h003D, 8'h00);
      check(order_fault_q, 2'b10);
      calibration_enable = 1'b1;
      wr(15'h0037, 8'h4B);
      check(order_fault_q, 2'b11);
      rst_n = 1'b0;
      cyc(2);
      check(order_fault_q, 2'b00);
      rst_n = 1'b1;
      cyc(10);
      rd_chk(15'h003E, 8'h20);
      calibration_enable = 1'b0;
      serial_link_enable = 1'b1;
      wr(15'h0037, 8'h4B);
      check(order_fault_q, 2'b01);
      serial_link_enable = 1'b0;
      $display("test order watch and reset done");
      final_report();
   end
endmodule : adcpw_regs_tb_top
